// ---- prsr_pkg.sv ----
// Package for the reference switchover and reference divider control block.
// Holds register indices, field positions, reset values and mode encodings.
// Assumes a 32-bit Avalon-MM register bus with word-aligned registers.
package prsr_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_LOOP_CTRL = 6'h10;  // Power-down, pump mode, polarity
   localparam logic [5:0] IDX_RDIV_LO = 6'h11;    // Divider bits 7:0
   localparam logic [5:0] IDX_RDIV_HI = 6'h12;    // Divider bits 13:8
   localparam logic [5:0] IDX_ABL = 6'h17;        // Antibacklash width
   localparam logic [5:0] IDX_SYNC_CTRL = 6'h19;  // Sync pin reset enable
   localparam logic [5:0] IDX_REF_CTRL = 6'h1C;   // Input type, switchover control
   localparam logic [5:0] IDX_REF_SEL = 6'h1D;    // Manual reference selection
   localparam logic [5:0] IDX_AUX_CTRL = 6'h20;   // Divider resets, pump current
   localparam logic [5:0] IDX_STATUS = 6'h21;     // Read-only switchover status

   // Reset values
   localparam logic [7:0] RST_LOOP_CTRL = 8'h01;  // Loop powered down
   localparam logic [7:0] RST_ZERO = 8'h00;

   // Loop control fields
   localparam int LOOP_PD_LO = 0;
   localparam int LOOP_PD_HI = 1;
   localparam logic [1:0] LOOP_PD_ON = 2'h0;      // Normal operation
   localparam int CP_MODE_LO = 4;
   localparam int CP_MODE_HI = 6;
   localparam int PD_POL_BIT = 7;

   // Charge pump mode encodings
   localparam logic [2:0] CP_MODE_HIZ = 3'h0;     // High impedance, holdover
   localparam logic [2:0] CP_MODE_UP = 3'h1;      // Constant pump up, test
   localparam logic [2:0] CP_MODE_DOWN = 3'h2;    // Constant pump down, test
   localparam logic [2:0] CP_MODE_NORMAL = 3'h3;  // Normal locking

   // Divider fields
   localparam int RDIV_W = 14;
   localparam int RDIV_HI_W = 6;
   localparam logic [RDIV_W-1:0] RDIV_ONE = 14'h0001;
   localparam int ABL_W = 2;
   localparam int SYNC_EN_LO = 6;
   localparam int SYNC_EN_HI = 7;

   // Reference control fields
   localparam int REF_DIFF_BIT = 0;     // Differential input selected
   localparam int REF_PRI_EN_BIT = 1;   // Primary single-ended buffer enable
   localparam int REF_SEC_EN_BIT = 2;   // Secondary single-ended buffer enable
   localparam int REF_STAY_BIT = 3;     // Stay on secondary, no revert
   localparam int REF_AUTO_BIT = 4;     // Automatic switchover mode
   localparam int REF_DGL_OFF_BIT = 7;  // Deglitch disabled

   // Manual selection fields
   localparam int SEL_SEC_BIT = 0;      // Register chooses secondary
   localparam int SEL_PIN_BIT = 1;      // Select pin has control

   // Auxiliary control fields
   localparam int AUX_RRST_BIT = 0;     // Divider own reset
   localparam int AUX_SHRST_BIT = 1;    // Shared counter reset
   localparam int AUX_CUR_LO = 2;
   localparam int AUX_CUR_HI = 4;

   // Status fields
   localparam int ST_ACT_SEC_BIT = 0;
   localparam int ST_MISSING_BIT = 1;
   localparam int ST_DGL_HOLD_BIT = 2;

   // Monitor thresholds
   localparam logic [1:0] MISS_FALLS = 2'h2;   // Secondary falls without primary edge
   localparam logic [2:0] RETURN_RISES = 3'h4; // Primary rises to declare return

   // Switchover states, Gray along primary, wait, secondary
   typedef enum logic [1:0] {
      SW_PRIMARY = 2'h0,
      SW_WAIT_SEC = 2'h1,
      SW_SECONDARY = 2'h3
   } prsr_state_t;

endpackage : prsr_pkg

// ---- prsr_ref_src.sv ----
// Two single-ended reference sources driven off the core clock.
// Assumes half periods well above four core cycles; primary may be stopped.
`timescale 1ns/1ps
`default_nettype none

module prsr_ref_src #(
   parameter int PRI_HALF = 6, // Primary half period in core cycles
   parameter int SEC_HALF = 7  // Secondary half period, unrelated ratio
) (
   // Clock and control
   input wire logic i_core_clk,
   input wire logic i_pri_run,
   // Reference lines
   output logic o_primary_ref = 1'b0,
   output logic o_secondary_ref = 1'b0
);
   int pc = 0; // Primary phase counter
   int sc = 0; // Secondary phase counter

   // A stopped primary holds its level, as a vanished source would
   always @(posedge i_core_clk) begin
      pc <= (pc == PRI_HALF - 1) ? 0 : pc + 1;
      sc <= (sc == SEC_HALF - 1) ? 0 : sc + 1;
      if (pc == PRI_HALF - 1 && i_pri_run) o_primary_ref <= ~o_primary_ref;
      if (sc == SEC_HALF - 1) o_secondary_ref <= ~o_secondary_ref;
   end
endmodule : prsr_ref_src

`default_nettype wire

// ---- prsr_top.sv ----
// Reference switchover, input buffer control and reference divider for a PLL.
// Assumes reference clocks slower than a quarter of i_core_clk, sampled as pins.
// Operation
// - Switchover only in single-ended input mode
// - Primary missing after two secondary falls
// - Secondary routed from next secondary rising edge
// - Revert after four primary rises when allowed
// - Stay mode: return via manual selection
// - Two auto modes: prefer-primary, stay-on-secondary
// - Manual choice by register or select pin
// - Deglitch blocks misaligned edges while switching
// - Fourteen-bit divider set through two bytes
// - Settings zero and one divide by one
// - Divider output feeds phase detector input
// - Divider reset by own, shared, sync
// - Three-bit charge pump mode field
// - Charge pump current in eight steps
// - Two-bit antibacklash width field
// - Register selects differential or single-ended
// - All reference inputs off after reset
// - Differential buffer down unless selected and on
// - Single-ended buffer down by loop or bit
// - Differential mode powers down single-ended buffers
// - Sync pin counter reset enabled, default off
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module prsr_top (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // Avalon-MM slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Reference and control pins
   input wire logic i_primary_ref,
   input wire logic i_secondary_ref,
   input wire logic i_ref_select_pin,
   input wire logic i_sync_n,
   // Phase detector side
   output logic o_phase_detector_ref,
   output logic o_phase_detector_polarity,
   output logic [1:0] o_antibacklash_width,
   // Charge pump side
   output logic [2:0] o_charge_pump_mode,
   output logic [2:0] o_charge_pump_current,
   // Buffer power and status
   output logic o_loop_powered_down,
   output logic o_diff_buf_pd,
   output logic o_primary_buf_pd,
   output logic o_secondary_buf_pd,
   output logic o_active_secondary,
   output logic o_primary_missing
);

   // Reset synchroniser
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Pin synchronisers: first stage, second stage, previous sample
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic [1:0] ref_prev;
   wire [3:0] pin_raw = {i_sync_n, i_ref_select_pin, i_secondary_ref, i_primary_ref};

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= 4'hC;
         pin_sync <= 4'hC;
         ref_prev <= 2'h0;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
         ref_prev <= pin_sync[1:0];
      end
   end

   // Edge events on the synchronised references
   wire pri_rise = pin_sync[0] & ~ref_prev[0];
   wire pri_edge = pin_sync[0] ^ ref_prev[0];
   wire sec_rise = pin_sync[1] & ~ref_prev[1];
   wire sec_fall = ~pin_sync[1] & ref_prev[1];
   wire sel_pin = pin_sync[2];
   wire sync_active = ~pin_sync[3];

   // Configuration registers
   localparam int RDIV_HI_W_L = prsr_pkg::RDIV_HI_W;
   localparam int RDIV_W_L = prsr_pkg::RDIV_W;
   logic [7:0] loop_ctrl;
   logic [7:0] rdiv_lo;
   logic [RDIV_HI_W_L-1:0] rdiv_hi;
   logic [1:0] abl;
   logic [1:0] sync_en;
   logic [7:0] ref_ctrl;
   logic [1:0] ref_sel;
   logic [4:0] aux_ctrl;

   // Bus decode
   wire [5:0] idx = i_avs_address[7:2];
   logic bus_ack;
   wire req = i_avs_read | i_avs_write;
   // Writes land only at the edge where waitrequest is low
   wire wr_go = i_avs_write & bus_ack & i_avs_byteenable[0];
   wire [7:0] wd = i_avs_writedata[7:0];
   wire wr_loop = wr_go && (idx == prsr_pkg::IDX_LOOP_CTRL);
   wire wr_rlo = wr_go && (idx == prsr_pkg::IDX_RDIV_LO);
   wire wr_rhi = wr_go && (idx == prsr_pkg::IDX_RDIV_HI);
   wire wr_abl = wr_go && (idx == prsr_pkg::IDX_ABL);
   wire wr_sync = wr_go && (idx == prsr_pkg::IDX_SYNC_CTRL);
   wire wr_ref = wr_go && (idx == prsr_pkg::IDX_REF_CTRL);
   wire wr_sel = wr_go && (idx == prsr_pkg::IDX_REF_SEL);
   wire wr_aux = wr_go && (idx == prsr_pkg::IDX_AUX_CTRL);

   // Answer one cycle after the request appears
   assign o_avs_waitrequest = req & ~bus_ack;

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_ack <= 1'b0;
      end else begin
         bus_ack <= req & ~bus_ack;
      end
   end

   // Register writes; everything but deglitch defaults to off
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         loop_ctrl <= prsr_pkg::RST_LOOP_CTRL;
         rdiv_lo <= prsr_pkg::RST_ZERO;
         rdiv_hi <= '0;
         abl <= '0;
         sync_en <= '0;
         ref_ctrl <= prsr_pkg::RST_ZERO;
         ref_sel <= '0;
         aux_ctrl <= '0;
      end else begin
         if (wr_loop) loop_ctrl <= wd;
         if (wr_rlo) rdiv_lo <= wd;
         if (wr_rhi) rdiv_hi <= wd[RDIV_HI_W_L-1:0];
         if (wr_abl) abl <= wd[prsr_pkg::ABL_W-1:0];
         if (wr_sync) sync_en <= wd[prsr_pkg::SYNC_EN_HI:prsr_pkg::SYNC_EN_LO];
         if (wr_ref) ref_ctrl <= wd;
         if (wr_sel) ref_sel <= wd[1:0];
         if (wr_aux) aux_ctrl <= wd[4:0];
      end
   end

   // Decoded controls
   wire loop_on = (loop_ctrl[prsr_pkg::LOOP_PD_HI:prsr_pkg::LOOP_PD_LO] == prsr_pkg::LOOP_PD_ON);
   wire diff_mode = ref_ctrl[prsr_pkg::REF_DIFF_BIT];
   wire pri_en = ref_ctrl[prsr_pkg::REF_PRI_EN_BIT];
   wire sec_en = ref_ctrl[prsr_pkg::REF_SEC_EN_BIT];
   wire stay_mode = ref_ctrl[prsr_pkg::REF_STAY_BIT];
   wire auto_mode = ref_ctrl[prsr_pkg::REF_AUTO_BIT] & ~diff_mode;
   wire deglitch_on = ~ref_ctrl[prsr_pkg::REF_DGL_OFF_BIT];
   // Manual selection from pin or register
   wire manual_sec = ref_sel[prsr_pkg::SEL_PIN_BIT] ? sel_pin : ref_sel[prsr_pkg::SEL_SEC_BIT];

   // Buffer power-down terms
   wire diff_pd = ~loop_on | ~diff_mode;
   wire pri_pd = ~loop_on | ~pri_en | diff_mode;
   wire sec_pd = ~loop_on | ~sec_en | diff_mode;

   // Primary monitor counters
   logic [1:0] miss_cnt;
   logic [2:0] ret_cnt;
   wire missing = (miss_cnt == prsr_pkg::MISS_FALLS);
   wire returned = (ret_cnt == prsr_pkg::RETURN_RISES);
   wire miss_event = sec_fall && (miss_cnt == prsr_pkg::MISS_FALLS - 2'h1);

   // Counts secondary falls since the last primary edge and primary rises since loss
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         miss_cnt <= '0;
         ret_cnt <= '0;
      end else begin
         if (pri_edge) begin
            miss_cnt <= '0; // Any primary edge proves it alive
         end else if (sec_fall && !missing) begin
            miss_cnt <= miss_cnt + 2'h1;
         end
         if (miss_event || (missing && sec_fall)) begin
            ret_cnt <= '0; // Two secondary falls between primary edges
         end else if (pri_rise && !returned) begin
            ret_cnt <= ret_cnt + 3'h1;
         end
      end
   end

   // Switchover state machine
   prsr_pkg::prsr_state_t sw_state;
   prsr_pkg::prsr_state_t next_sw_state;

   always_comb begin
      next_sw_state = sw_state;
      if (diff_mode) begin
         next_sw_state = prsr_pkg::SW_PRIMARY;
      end else if (!auto_mode) begin
         // Manual mode follows the selection, which also rearms auto
         next_sw_state = manual_sec ? prsr_pkg::SW_SECONDARY : prsr_pkg::SW_PRIMARY;
      end else begin
         case (sw_state)
            prsr_pkg::SW_PRIMARY: begin
               if (missing) next_sw_state = prsr_pkg::SW_WAIT_SEC;
            end
            prsr_pkg::SW_WAIT_SEC: begin
               if (sec_rise) next_sw_state = prsr_pkg::SW_SECONDARY;
            end
            prsr_pkg::SW_SECONDARY: begin
               // Prefer-primary reverts, stay mode holds
               if (!stay_mode && returned && !missing) next_sw_state = prsr_pkg::SW_PRIMARY;
            end
            default: begin
               next_sw_state = prsr_pkg::SW_PRIMARY;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_state <= prsr_pkg::SW_PRIMARY;
      end else begin
         sw_state <= next_sw_state;
      end
   end

   // Deglitch: after a change of reference, no edge passes until the new one rises
   wire want_sec = (sw_state == prsr_pkg::SW_SECONDARY);
   logic mux_sec;
   logic dgl_hold;
   wire sel_rise = mux_sec ? sec_rise : pri_rise;
   wire sel_alive = mux_sec ? ~sec_pd : (diff_mode ? ~diff_pd : ~pri_pd);

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mux_sec <= 1'b0;
         dgl_hold <= 1'b0;
      end else begin
         if (want_sec != mux_sec) begin
            mux_sec <= want_sec;
            dgl_hold <= deglitch_on;
         end else if (sel_rise || !deglitch_on) begin
            dgl_hold <= 1'b0; // First edge of the new reference is aligned
         end
      end
   end

   // Reference edge presented to the divider
   wire div_in = sel_rise & sel_alive & loop_on & ~dgl_hold;

   // Reference divider
   wire [RDIV_W_L-1:0] r_set = {rdiv_hi, rdiv_lo};
   wire [RDIV_W_L-1:0] r_eff = (r_set <= prsr_pkg::RDIV_ONE) ? prsr_pkg::RDIV_ONE : r_set;
   wire r_reset = aux_ctrl[prsr_pkg::AUX_RRST_BIT] | aux_ctrl[prsr_pkg::AUX_SHRST_BIT]
                  | ((|sync_en) & sync_active);
   logic [RDIV_W_L-1:0] r_cnt;
   // Wrap at or past the end, so a setting lowered below the count cannot run away
   wire r_wrap = (r_cnt >= r_eff - prsr_pkg::RDIV_ONE);

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_cnt <= '0;
      end else if (r_reset) begin
         r_cnt <= '0;
      end else if (div_in) begin
         r_cnt <= r_wrap ? '0 : r_cnt + prsr_pkg::RDIV_ONE;
      end
   end

   // Registered outputs
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_phase_detector_ref <= 1'b0;
         o_phase_detector_polarity <= 1'b0;
         o_antibacklash_width <= '0;
         o_charge_pump_mode <= prsr_pkg::CP_MODE_HIZ;
         o_charge_pump_current <= '0;
         o_loop_powered_down <= 1'b1;
         o_diff_buf_pd <= 1'b1;
         o_primary_buf_pd <= 1'b1;
         o_secondary_buf_pd <= 1'b1;
         o_active_secondary <= 1'b0;
         o_primary_missing <= 1'b0;
      end else begin
         o_phase_detector_ref <= div_in & r_wrap & ~r_reset;
         o_phase_detector_polarity <= loop_ctrl[prsr_pkg::PD_POL_BIT];
         o_antibacklash_width <= abl;
         o_charge_pump_mode <= loop_ctrl[prsr_pkg::CP_MODE_HI:prsr_pkg::CP_MODE_LO];
         o_charge_pump_current <= aux_ctrl[prsr_pkg::AUX_CUR_HI:prsr_pkg::AUX_CUR_LO];
         o_loop_powered_down <= ~loop_on;
         o_diff_buf_pd <= diff_pd;
         o_primary_buf_pd <= pri_pd;
         o_secondary_buf_pd <= sec_pd;
         o_active_secondary <= mux_sec;
         o_primary_missing <= missing & ~diff_mode;
      end
   end

   // Read data mux, unmapped reads give zero
   logic [7:0] rd_byte;

   always_comb begin
      if (idx == prsr_pkg::IDX_LOOP_CTRL) rd_byte = loop_ctrl;
      else if (idx == prsr_pkg::IDX_RDIV_LO) rd_byte = rdiv_lo;
      else if (idx == prsr_pkg::IDX_RDIV_HI) rd_byte = {2'h0, rdiv_hi};
      else if (idx == prsr_pkg::IDX_ABL) rd_byte = {6'h00, abl};
      else if (idx == prsr_pkg::IDX_SYNC_CTRL) rd_byte = {sync_en, 6'h00};
      else if (idx == prsr_pkg::IDX_REF_CTRL) rd_byte = ref_ctrl;
      else if (idx == prsr_pkg::IDX_REF_SEL) rd_byte = {6'h00, ref_sel};
      else if (idx == prsr_pkg::IDX_AUX_CTRL) rd_byte = {3'h0, aux_ctrl};
      else if (idx == prsr_pkg::IDX_STATUS) rd_byte = {5'h00, dgl_hold, missing, mux_sec};
      else rd_byte = 8'h00;
   end

   // Read data captured at the answering edge, held until the next read
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_avs_readdata <= 32'h0000_0000;
      end else if (i_avs_read && !bus_ack) begin
         o_avs_readdata <= {24'h000000, rd_byte};
      end
   end

endmodule : prsr_top

`default_nettype wire

// ---- prsr_top_assertions.sv ----
// Concurrent checks on the ports of the switchover and divider block.
// Assumes one clock, i_rstn as reset, and a master leaving idle gaps.
`timescale 1ns/1ps
`default_nettype none

module prsr_top_chk (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // Register bus
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // Reference pins and loop outputs
   input wire logic i_primary_ref,
   input wire logic i_secondary_ref,
   input wire logic o_phase_detector_ref,
   input wire logic o_loop_powered_down,
   input wire logic o_diff_buf_pd,
   input wire logic o_primary_buf_pd,
   input wire logic o_secondary_buf_pd,
   input wire logic o_active_secondary
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   logic pri_q; // Previous primary level
   logic sec_q; // Previous secondary level
   logic [5:0] rise_hist; // Recent rises on either reference
   wire logic req = i_avs_read | i_avs_write; // Any request pending

   // Remember recent reference rises so a pulse can be traced to one
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pri_q <= 1'b0;
         sec_q <= 1'b0;
         rise_hist <= 6'h00;
      end else begin
         pri_q <= i_primary_ref;
         sec_q <= i_secondary_ref;
         rise_hist <= {rise_hist[4:0], (i_primary_ref & ~pri_q) | (i_secondary_ref & ~sec_q)};
      end
   end

   // Request opens, then one wait cycle, then acknowledge
   sequence req_start;
      req && !$past(req);
   endsequence
   sequence wait_then_ack;
      o_avs_waitrequest ##1 !o_avs_waitrequest;
   endsequence

   wait_once_a: assert property (req_start |-> wait_then_ack)
      else $error("waitrequest not one cycle");
   wait_idle_a: assert property (!req |-> !o_avs_waitrequest)
      else $error("waitrequest without request");
   rdata_hold_a: assert property (!i_avs_read |=> $stable(o_avs_readdata))
      else $error("readdata changed without read");
   rdata_top_a: assert property (o_avs_readdata[31:8] == 24'h000000)
      else $error("readdata upper bits set");
   loop_off_a: assert property (o_loop_powered_down |->
      o_diff_buf_pd && o_primary_buf_pd && o_secondary_buf_pd)
      else $error("buffer on while loop down");
   diff_mode_a: assert property (!o_diff_buf_pd |->
      o_primary_buf_pd && o_secondary_buf_pd)
      else $error("single-ended buffer on in differential mode");
   diff_noswap_a: assert property (!o_diff_buf_pd [*3] |-> !o_active_secondary)
      else $error("switchover in differential mode");
   pulse_one_a: assert property (o_phase_detector_ref |=> !o_phase_detector_ref)
      else $error("divider pulse longer than one cycle");
   pulse_cause_a: assert property (o_phase_detector_ref |-> rise_hist != 6'h00)
      else $error("divider pulse without reference edge");
   pulse_off_a: assert property (o_loop_powered_down [*4] |-> !o_phase_detector_ref)
      else $error("divider pulse while loop down");

endmodule : prsr_top_chk

bind prsr_top prsr_top_chk u_chk (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_primary_ref(i_primary_ref),
   .i_secondary_ref(i_secondary_ref), .o_phase_detector_ref(o_phase_detector_ref),
   .o_loop_powered_down(o_loop_powered_down), .o_diff_buf_pd(o_diff_buf_pd),
   .o_primary_buf_pd(o_primary_buf_pd), .o_secondary_buf_pd(o_secondary_buf_pd),
   .o_active_secondary(o_active_secondary));

`default_nettype wire

// ---- prsr_top_tb.sv ----
// Self-checking bench for the switchover and divider block.
// Assumes the reference source model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module prsr_top_tb;
   logic clk = 1'b0; // Core clock
   logic rstn = 1'b0; // Raw reset
   logic rd = 1'b0, wr = 1'b0, sel_pin = 1'b0, sync_n = 1'b1, pri_run = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] be = 4'hF;
   wire logic pri, sec, wreq, pd_ref, pol, loop_pd, dpd, ppd, spd, act, miss;
   wire logic [31:0] rdata;
   wire logic [1:0] abl;
   wire logic [2:0] cpm, cpi;
   int n_mismatch = 0;
   int total_checks = 0;
   int pcnt = 0; // Divider pulses seen
   int m;
   logic [7:0] q;

   // Clock and pulse counting
   initial forever #10 clk = ~clk;
   always @(posedge clk) if (pd_ref === 1'b1) pcnt <= pcnt + 1;

   prsr_ref_src src (.i_core_clk(clk), .i_pri_run(pri_run), .o_primary_ref(pri),
      .o_secondary_ref(sec));
   prsr_top dut (.i_core_clk(clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_primary_ref(pri),
      .i_secondary_ref(sec), .i_ref_select_pin(sel_pin), .i_sync_n(sync_n),
      .o_phase_detector_ref(pd_ref), .o_phase_detector_polarity(pol),
      .o_antibacklash_width(abl), .o_charge_pump_mode(cpm), .o_charge_pump_current(cpi),
      .o_loop_powered_down(loop_pd), .o_diff_buf_pd(dpd), .o_primary_buf_pd(ppd),
      .o_secondary_buf_pd(spd), .o_active_secondary(act), .o_primary_missing(miss));

   // Verdict and end of run
   task automatic test_done();
      if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done

   // A wait ran out
   task automatic tmo();
      n_mismatch++;
      test_done();
   endtask : tmo

   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d,
                      input logic [3:0] b, output logic [7:0] r);
      int n;
      @(posedge clk);
      addr <= {idx, 2'h0};
      wdata <= {24'h000000, d};
      be <= b;
      if (w) wr <= 1'b1;
      else rd <= 1'b1;
      n = 0;
      // Waitrequest is sampled at the rising edge; data is taken at that same edge
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      if (n >= 20) tmo();
      r = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic wr8(input logic [5:0] idx, input logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, idx, d, 4'hF, r);
   endtask : wr8

   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00, 4'hF, q);
      `CHK(q, e)
   endtask : rd_chk

   // Let registered outputs follow a write
   task automatic settle();
      repeat (3) @(posedge clk);
   endtask : settle

   // Count n primary transitions to level v
   task automatic wait_edge(input int n, input logic v);
      int k, c;
      logic p0;
      k = 0;
      c = 0;
      p0 = pri;
      while (k < n && c < 40 * n) begin
         @(posedge clk);
         c++;
         if (pri === v && p0 === ~v) k++;
         p0 = pri;
      end
      if (k < n) tmo();
   endtask : wait_edge

   // Divider pulses over n primary rises
   task automatic pulses(input int n, input int e);
      int c0;
      c0 = pcnt;
      wait_edge(n, 1'b1);
      repeat (6) @(posedge clk);
      `CHK(pcnt - c0, e)
   endtask : pulses

   // Wait for the active reference to become v
   task automatic wait_act(input logic v);
      int c;
      for (c = 0; c < 400 && act !== v; c++) @(posedge clk);
      if (act !== v) tmo();
      `CHK(act, v)
   endtask : wait_act

   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(prsr_pkg::IDX_LOOP_CTRL, prsr_pkg::RST_LOOP_CTRL);
      rd_chk(prsr_pkg::IDX_REF_CTRL, 8'h00);
      rd_chk(prsr_pkg::IDX_SYNC_CTRL, 8'h00);
      `CHK({loop_pd, dpd, ppd, spd, cpm}, 7'h78)
      rd_chk(6'h3F, 8'h00);
      bus(1'b1, prsr_pkg::IDX_ABL, 8'h03, 4'hE, q);
      rd_chk(prsr_pkg::IDX_ABL, 8'h00);
      wr8(prsr_pkg::IDX_ABL, 8'h03);
      settle();
      `CHK(abl, 2'h3)
      for (m = 0; m < 4; m++) begin
         wr8(prsr_pkg::IDX_LOOP_CTRL, {m[0], m[2:0], 4'h0});
         settle();
         `CHK({pol, cpm}, {m[0], m[2:0]})
      end
      for (m = 0; m < 8; m++) begin
         wr8(prsr_pkg::IDX_AUX_CTRL, {3'h0, m[2:0], 2'h0});
         settle();
         `CHK(cpi, m[2:0])
      end
      wr8(prsr_pkg::IDX_REF_CTRL, 8'h01);
      settle();
      `CHK({dpd, ppd, spd}, 3'h3)
      wr8(prsr_pkg::IDX_REF_CTRL, 8'h04);
      settle();
      `CHK({dpd, ppd, spd}, 3'h6)
      wr8(prsr_pkg::IDX_REF_CTRL, 8'h06);
      settle();
      `CHK({dpd, ppd, spd}, 3'h4)
      wr8(prsr_pkg::IDX_LOOP_CTRL, 8'h31);
      settle();
      `CHK({loop_pd, dpd, ppd, spd}, 4'hF)
      wr8(prsr_pkg::IDX_LOOP_CTRL, 8'h30);
      wr8(prsr_pkg::IDX_RDIV_LO, 8'hFF);
      wr8(prsr_pkg::IDX_RDIV_HI, 8'h3F);
      rd_chk(prsr_pkg::IDX_RDIV_LO, 8'hFF);
      rd_chk(prsr_pkg::IDX_RDIV_HI, 8'h3F);
      wr8(prsr_pkg::IDX_RDIV_HI, 8'h00);
      for (m = 0; m < 2; m++) begin
         wr8(prsr_pkg::IDX_RDIV_LO, m[7:0]);
         wait_edge(1, 1'b0); // Start in the low phase, no pulse pending
         pulses(3, 3);
      end
      wr8(prsr_pkg::IDX_RDIV_LO, 8'h03);
      wait_edge(1, 1'b0);
      sync_n <= 1'b0;
      pulses(3, 1);
      sync_n <= 1'b1;
      wr8(prsr_pkg::IDX_SYNC_CTRL, 8'hC0);
      for (m = 0; m < 3; m++) begin
         wait_edge(1, 1'b0);
         if (m == 2) sync_n <= 1'b0;
         else wr8(prsr_pkg::IDX_AUX_CTRL, m == 0 ? 8'h01 : 8'h02);
         pulses(3, 0);
         wait_edge(1, 1'b0);
         if (m == 2) sync_n <= 1'b1;
         else wr8(prsr_pkg::IDX_AUX_CTRL, 8'h00);
         pulses(2, 0);
         pulses(1, 1);
      end
      wr8(prsr_pkg::IDX_REF_CTRL, 8'h16);
      pri_run <= 1'b0;
      wait_act(1'b1);
      `CHK(miss, 1'b1)
      rd_chk(prsr_pkg::IDX_STATUS, 8'h07);
      pri_run <= 1'b1;
      wait_edge(3, 1'b1);
      `CHK(act, 1'b1)
      wait_edge(2, 1'b1);
      settle();
      `CHK(act, 1'b0)
      wr8(prsr_pkg::IDX_REF_CTRL, 8'h1E);
      pri_run <= 1'b0;
      wait_act(1'b1);
      pri_run <= 1'b1;
      wait_edge(6, 1'b1);
      `CHK(act, 1'b1)
      wr8(prsr_pkg::IDX_REF_CTRL, 8'h0E);
      wr8(prsr_pkg::IDX_REF_SEL, 8'h00);
      wait_act(1'b0);
      wr8(prsr_pkg::IDX_REF_CTRL, 8'h8E);
      wr8(prsr_pkg::IDX_REF_SEL, 8'h01);
      wait_act(1'b1);
      wr8(prsr_pkg::IDX_REF_SEL, 8'h02);
      wait_act(1'b0);
      sel_pin <= 1'b1;
      wait_act(1'b1);
      wr8(prsr_pkg::IDX_REF_CTRL, 8'h01);
      wait_act(1'b0);
      test_done();
   end
endmodule : prsr_top_tb

`undef CHK
`default_nettype wire
